// ---- hdl/uec_pkg.sv ----
// package: register map, field layout and constants of the endpoint configuration bank
package uec_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_EP = 8;
	localparam int EP_IDX_W = 3;
	localparam int ADR_W = 12;
	localparam int SIZE_W = 11;
	localparam int TOTAL_W = 15;
	localparam logic [TOTAL_W-1:0] FIFO_LIMIT_BYTES = 15'h2000;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADR_W-1:0] OFS_FIFO_SIZE = 12'h204;
	localparam logic [ADR_W-1:0] OFS_TYPE_CTRL = 12'h208;
	localparam logic [ADR_W-1:0] OFS_BYTE_COUNT = 12'h21c;
	localparam logic [ADR_W-1:0] OFS_EP_INDEX = 12'h22c;
	localparam logic [ADR_W-1:0] OFS_ALLOC_STATUS = 12'h240;

	// ----------------------------------------------------------------
	// endpoint_fifo_size fields
	// ----------------------------------------------------------------
	localparam int FS_SIZE_LSB = 0;
	localparam int FS_TRANSACTIONS_PER_MICROFRAME_LSB = 11;
	localparam int FS_STORE_W = 13;
	localparam logic [FS_STORE_W-1:0] FS_RESET = 13'h0000;
	localparam logic [1:0] TRANSACTIONS_PER_MICROFRAME_ONE = 2'h0;
	localparam logic [1:0] TRANSACTIONS_PER_MICROFRAME_TWO = 2'h1;
	localparam logic [1:0] TRANSACTIONS_PER_MICROFRAME_THREE = 2'h2;
	localparam logic [1:0] TRANSACTIONS_PER_MICROFRAME_RSVD = 2'h3;

	// ----------------------------------------------------------------
	// endpoint_type_control fields
	// ----------------------------------------------------------------
	localparam int TY_KIND_LSB = 0;
	localparam int TY_DBL_BIT = 2;
	localparam int TY_EN_BIT = 3;
	localparam int TY_NOZLP_BIT = 4;
	localparam int TY_STORE_W = 5;
	localparam logic [TY_STORE_W-1:0] TY_RESET = 5'h00;
	localparam logic [1:0] KIND_UNUSED = 2'h0;
	localparam logic [1:0] KIND_ISO = 2'h1;
	localparam logic [1:0] KIND_BULK = 2'h2;
	localparam logic [1:0] KIND_INTR = 2'h3;

	// ----------------------------------------------------------------
	// other reset values and status layout
	// ----------------------------------------------------------------
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [EP_IDX_W-1:0] IDX_RESET = 3'h0;
	localparam int ST_OVER_BIT = 16;

endpackage : uec_pkg

// ---- hdl/uec_alloc_sum.sv ----
// module: totals the fifo memory claimed by the enabled endpoints
`timescale 1ns/1ns
`default_nettype none
module uec_alloc_sum (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [uec_pkg::NUM_EP-1:0] en_i,
	input wire logic [uec_pkg::NUM_EP-1:0] dbl_i,
	input wire logic [uec_pkg::NUM_EP*uec_pkg::SIZE_W-1:0] size_i,
	output logic [uec_pkg::TOTAL_W-1:0] total_o,
	output logic over_o
);
	logic [uec_pkg::SIZE_W:0] term [uec_pkg::NUM_EP];
	logic [uec_pkg::TOTAL_W-1:0] total_next;
	logic over_next;

	// ----------------------------------------------------------------
	// per-endpoint claim
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < uec_pkg::NUM_EP; g++) begin : g_term
			logic [uec_pkg::SIZE_W-1:0] sz;
			assign sz = size_i[g*uec_pkg::SIZE_W +: uec_pkg::SIZE_W];
			// disabled endpoints claim nothing; double buffer claims twice
			assign term[g] = !en_i[g] ? '0 : (dbl_i[g] ? {sz, 1'b0} : {1'b0, sz});
		end
	endgenerate

	// ----------------------------------------------------------------
	// sum and limit check
	// ----------------------------------------------------------------
	always_comb begin
		total_next = '0;
		for (int i = 0; i < uec_pkg::NUM_EP; i++) begin
			total_next = total_next + uec_pkg::TOTAL_W'(term[i]);
		end
		// the limit itself is software's to keep; this flag only reports a breach
		over_next = total_next > uec_pkg::FIFO_LIMIT_BYTES;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			total_o <= '0;
			over_o <= 1'b0;
		end else if (ce_i) begin
			total_o <= total_next;
			over_o <= over_next;
		end
	end

	a_over_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i |=> over_o == ($past(total_next) > uec_pkg::FIFO_LIMIT_BYTES))
		else $error("over-limit flag disagrees with total");

endmodule : uec_alloc_sum
`default_nettype wire

// ---- hdl/uec_regs.sv ----
// module: per-endpoint configuration registers behind a classic wishbone slave
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module uec_regs (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [uec_pkg::ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire logic usb_bus_reset_i,
	input wire logic hs_mode_i,
	input wire logic [uec_pkg::EP_IDX_W-1:0] usb_ep_sel_i,
	output logic ep_enable_o,
	output logic [1:0] ep_kind_o,
	output logic ep_double_buffer_o,
	output logic ep_suppress_zlp_o,
	output logic [uec_pkg::SIZE_W-1:0] ep_fifo_size_o,
	output logic [1:0] ep_trans_o,
	output logic [15:0] ep_byte_count_o,
	output logic toggle_reset_o,
	output logic [uec_pkg::EP_IDX_W-1:0] toggle_ep_o,
	output logic [uec_pkg::TOTAL_W-1:0] alloc_total_o,
	output logic alloc_over_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [uec_pkg::FS_STORE_W-1:0] fs_reg [uec_pkg::NUM_EP];
	logic [uec_pkg::FS_STORE_W-1:0] fs_next [uec_pkg::NUM_EP];
	logic [uec_pkg::TY_STORE_W-1:0] ty_reg [uec_pkg::NUM_EP];
	logic [uec_pkg::TY_STORE_W-1:0] ty_next [uec_pkg::NUM_EP];
	logic [15:0] cnt_reg [uec_pkg::NUM_EP];
	logic [15:0] cnt_next [uec_pkg::NUM_EP];
	logic [uec_pkg::EP_IDX_W-1:0] idx_reg;
	logic [uec_pkg::EP_IDX_W-1:0] idx_next;
	logic ack_reg;
	logic ack_next;
	logic [31:0] rdat_reg;
	logic [31:0] rdat_next;
	logic tgl_reg;
	logic tgl_next;
	logic [uec_pkg::EP_IDX_W-1:0] tgl_ep_reg;
	logic [uec_pkg::EP_IDX_W-1:0] tgl_ep_next;
	logic en_reg;
	logic en_next;
	logic [1:0] kind_reg;
	logic [1:0] kind_next;
	logic dbl_reg;
	logic dbl_next;
	logic nozlp_reg;
	logic nozlp_next;
	logic [uec_pkg::SIZE_W-1:0] size_reg;
	logic [uec_pkg::SIZE_W-1:0] size_next;
	logic [1:0] trans_reg;
	logic [1:0] trans_next;
	logic [15:0] bcnt_reg;
	logic [15:0] bcnt_next;

	logic wr_take;
	logic rd_start;
	logic [15:0] wmerge;
	logic [uec_pkg::NUM_EP-1:0] en_vec;
	logic [uec_pkg::NUM_EP-1:0] dbl_vec;
	logic [uec_pkg::NUM_EP*uec_pkg::SIZE_W-1:0] size_vec;

	// byte lanes 0 and 1 carry the 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
		input logic [1:0] lanes);
		merge16 = {lanes[1] ? new_v[15:8] : old_v[15:8], lanes[0] ? new_v[7:0] : old_v[7:0]};
	endfunction : merge16

	// ----------------------------------------------------------------
	// wishbone slave and register writes
	// ----------------------------------------------------------------
	// a write lands at the edge where the master sees ack, so one cycle after the request
	assign wr_take = cyc_i && stb_i && we_i && ack_reg;
	assign rd_start = cyc_i && stb_i && !ack_reg;

	always_comb begin
		fs_next = fs_reg;
		ty_next = ty_reg;
		cnt_next = cnt_reg;
		idx_next = idx_reg;
		tgl_next = 1'b0;
		tgl_ep_next = tgl_ep_reg;
		ack_next = cyc_i && stb_i && !ack_reg;
		rdat_next = rdat_reg;
		wmerge = 16'h0000;
		if (rd_start) begin
			unique case (adr_i)
				// reserved bits read as zero
				uec_pkg::OFS_FIFO_SIZE: rdat_next = {19'h0, fs_reg[idx_reg]};
				uec_pkg::OFS_TYPE_CTRL: rdat_next = {27'h0, ty_reg[idx_reg]};
				uec_pkg::OFS_BYTE_COUNT: rdat_next = {16'h0, cnt_reg[idx_reg]};
				uec_pkg::OFS_EP_INDEX: rdat_next = {29'h0, idx_reg};
				uec_pkg::OFS_ALLOC_STATUS: rdat_next = {15'h0, alloc_over_o, 1'b0, alloc_total_o};
				default: rdat_next = 32'h0000_0000;
			endcase
		end
		if (usb_bus_reset_i) begin
			// bus reset clears the configuration and the byte counts
			for (int i = 0; i < uec_pkg::NUM_EP; i++) begin
				fs_next[i] = uec_pkg::FS_RESET;
				ty_next[i] = uec_pkg::TY_RESET;
				cnt_next[i] = uec_pkg::CNT_RESET;
			end
		end else if (wr_take) begin
			unique case (adr_i)
				uec_pkg::OFS_FIFO_SIZE: begin
					// reserved bits 15..13 are not stored; software writes them as zero
					wmerge = merge16({3'h0, fs_reg[idx_reg]}, dat_i[15:0], sel_i[1:0]);
					fs_next[idx_reg] = wmerge[uec_pkg::FS_STORE_W-1:0];
					cnt_next[idx_reg] = {5'h00, wmerge[uec_pkg::SIZE_W-1:0]};
				end
				uec_pkg::OFS_TYPE_CTRL: begin
					wmerge = merge16({11'h000, ty_reg[idx_reg]}, dat_i[15:0], sel_i[1:0]);
					ty_next[idx_reg] = wmerge[uec_pkg::TY_STORE_W-1:0];
					// a rising enable restarts the data toggle of that endpoint
					if (!ty_reg[idx_reg][uec_pkg::TY_EN_BIT] && wmerge[uec_pkg::TY_EN_BIT]) begin
						tgl_next = 1'b1;
						tgl_ep_next = idx_reg;
					end
				end
				uec_pkg::OFS_BYTE_COUNT: begin
					cnt_next[idx_reg] = merge16(cnt_reg[idx_reg], dat_i[15:0], sel_i[1:0]);
				end
				uec_pkg::OFS_EP_INDEX: begin
					if (sel_i[0]) begin
						idx_next = dat_i[uec_pkg::EP_IDX_W-1:0];
					end
				end
				default: begin
					wmerge = 16'h0000;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// view of the endpoint the usb engine is serving
	// ----------------------------------------------------------------
	always_comb begin
		en_next = ty_reg[usb_ep_sel_i][uec_pkg::TY_EN_BIT];
		kind_next = ty_reg[usb_ep_sel_i][uec_pkg::TY_KIND_LSB +: 2];
		dbl_next = ty_reg[usb_ep_sel_i][uec_pkg::TY_DBL_BIT];
		nozlp_next = ty_reg[usb_ep_sel_i][uec_pkg::TY_NOZLP_BIT];
		size_next = fs_reg[usb_ep_sel_i][uec_pkg::FS_SIZE_LSB +: uec_pkg::SIZE_W];
		bcnt_next = cnt_reg[usb_ep_sel_i];
		trans_next = uec_pkg::TRANSACTIONS_PER_MICROFRAME_ONE;
		// only high speed periodic endpoints see the count; reserved code falls back to one
		if (hs_mode_i && (kind_next == uec_pkg::KIND_ISO || kind_next == uec_pkg::KIND_INTR)
			&& fs_reg[usb_ep_sel_i][uec_pkg::FS_TRANSACTIONS_PER_MICROFRAME_LSB +: 2] != uec_pkg::TRANSACTIONS_PER_MICROFRAME_RSVD) begin
			trans_next = fs_reg[usb_ep_sel_i][uec_pkg::FS_TRANSACTIONS_PER_MICROFRAME_LSB +: 2];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < uec_pkg::NUM_EP; i++) begin
				fs_reg[i] <= uec_pkg::FS_RESET;
				ty_reg[i] <= uec_pkg::TY_RESET;
				cnt_reg[i] <= uec_pkg::CNT_RESET;
			end
			idx_reg <= uec_pkg::IDX_RESET;
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
			tgl_reg <= 1'b0;
			tgl_ep_reg <= uec_pkg::IDX_RESET;
			en_reg <= 1'b0;
			kind_reg <= uec_pkg::KIND_UNUSED;
			dbl_reg <= 1'b0;
			nozlp_reg <= 1'b0;
			size_reg <= '0;
			trans_reg <= uec_pkg::TRANSACTIONS_PER_MICROFRAME_ONE;
			bcnt_reg <= uec_pkg::CNT_RESET;
		end else if (ce_i) begin
			fs_reg <= fs_next;
			ty_reg <= ty_next;
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
			tgl_reg <= tgl_next;
			tgl_ep_reg <= tgl_ep_next;
			en_reg <= en_next;
			kind_reg <= kind_next;
			dbl_reg <= dbl_next;
			nozlp_reg <= nozlp_next;
			size_reg <= size_next;
			trans_reg <= trans_next;
			bcnt_reg <= bcnt_next;
		end
	end

	// ----------------------------------------------------------------
	// memory claim of enabled endpoints
	// ----------------------------------------------------------------
	generate
		for (genvar e = 0; e < uec_pkg::NUM_EP; e++) begin : g_flat
			assign en_vec[e] = ty_reg[e][uec_pkg::TY_EN_BIT];
			assign dbl_vec[e] = ty_reg[e][uec_pkg::TY_DBL_BIT];
			assign size_vec[e*uec_pkg::SIZE_W +: uec_pkg::SIZE_W] = fs_reg[e][uec_pkg::SIZE_W-1:0];
		end
	endgenerate

	uec_alloc_sum u_alloc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.en_i(en_vec),
		.dbl_i(dbl_vec),
		.size_i(size_vec),
		.total_o(alloc_total_o),
		.over_o(alloc_over_o)
	);

	assign dat_o = rdat_reg;
	assign ack_o = ack_reg;
	assign toggle_reset_o = tgl_reg;
	assign toggle_ep_o = tgl_ep_reg;
	assign ep_enable_o = en_reg;
	assign ep_kind_o = kind_reg;
	assign ep_double_buffer_o = dbl_reg;
	assign ep_suppress_zlp_o = nozlp_reg;
	assign ep_fifo_size_o = size_reg;
	assign ep_trans_o = trans_reg;
	assign ep_byte_count_o = bcnt_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_trans_no_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
		ep_trans_o != uec_pkg::TRANSACTIONS_PER_MICROFRAME_RSVD)
		else $error("reserved transaction code reached the engine");

	a_trans_fs_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && (!hs_mode_i || kind_next == uec_pkg::KIND_BULK) |=> ep_trans_o == uec_pkg::TRANSACTIONS_PER_MICROFRAME_ONE)
		else $error("transaction count applied outside high speed periodic");

	a_size_reload: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && wr_take && !usb_bus_reset_i && adr_i == uec_pkg::OFS_FIFO_SIZE && sel_i[1:0] == 2'h3
		|=> cnt_reg[$past(idx_reg)] == {5'h00, $past(dat_i[10:0])})
		else $error("byte count not reloaded from fifo size");

	a_kind_write: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && wr_take && !usb_bus_reset_i && adr_i == uec_pkg::OFS_TYPE_CTRL && sel_i[0]
		|=> ty_reg[$past(idx_reg)][1:0] == $past(dat_i[1:0]))
		else $error("endpoint kind not stored");

	a_bus_reset_clr: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && usb_bus_reset_i |=> ty_reg[0] == '0 && ty_reg[uec_pkg::NUM_EP-1] == '0)
		else $error("type register survived bus reset");

	// the old enable is looked up through the index that the pulse was raised for
	a_toggle_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && toggle_reset_o |-> ty_reg[toggle_ep_o][uec_pkg::TY_EN_BIT]
		&& !$past(ty_reg[tgl_ep_next][uec_pkg::TY_EN_BIT]))
		else $error("toggle reset without a rising enable");

	a_enable_view: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i |=> ep_enable_o == $past(ty_reg[usb_ep_sel_i][uec_pkg::TY_EN_BIT]))
		else $error("enable not presented for selected endpoint");

	a_zlp_view: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i |=> ep_suppress_zlp_o == $past(ty_reg[usb_ep_sel_i][uec_pkg::TY_NOZLP_BIT]))
		else $error("zero length suppression not presented");

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && cyc_i && stb_i && !ack_o |=> ack_o ##1 (!ack_o || !$past(ce_i)))
		else $error("ack not one cycle after request");

endmodule : uec_regs
`default_nettype wire

// ---- tb/uec_usb_host_model.sv ----
// file: behavioural usb engine side that steers endpoint select, speed and bus reset
`timescale 1ns/1ns
`default_nettype none
module uec_usb_host_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [uec_pkg::EP_IDX_W-1:0] sel_req_i,
	input wire logic hs_req_i,
	input wire logic bus_reset_req_i,
	input wire logic toggle_reset_i,
	input wire logic [uec_pkg::EP_IDX_W-1:0] toggle_ep_i,
	output logic [uec_pkg::EP_IDX_W-1:0] usb_ep_sel_o,
	output logic hs_mode_o,
	output logic usb_bus_reset_o,
	output logic [7:0] toggle_count_o,
	output logic [uec_pkg::EP_IDX_W-1:0] toggle_last_o
);
	// ----------------------------------------------------------------
	// one flop of lag, as a real engine registers its endpoint choice
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			usb_ep_sel_o <= 3'h0;
			hs_mode_o <= 1'b0;
			usb_bus_reset_o <= 1'b0;
			toggle_count_o <= 8'h00;
			toggle_last_o <= 3'h0;
		end else begin
			usb_ep_sel_o <= sel_req_i;
			hs_mode_o <= hs_req_i;
			usb_bus_reset_o <= bus_reset_req_i;
			// pid reset requests are counted so the bench can see each one
			if (toggle_reset_i) begin
				toggle_count_o <= toggle_count_o + 8'h01;
				toggle_last_o <= toggle_ep_i;
			end
		end
	end
endmodule : uec_usb_host_model
`default_nettype wire

// ---- tb/uec_regs_tb_top.sv ----
// file: self-checking bench for the endpoint configuration register bank
`timescale 1ns/1ns
`default_nettype none
module uec_regs_tb_top;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] adr = 12'h000;
	logic [31:0] wdat = 32'h0;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic [3:0] sel = 4'h0;
	logic ce = 1'b1;
	logic [31:0] dat_o;
	logic ack_o;
	logic [2:0] sel_req = 3'h0;
	logic hs_req = 1'b0;
	logic br_req = 1'b0;
	logic [2:0] ep_sel, tog_ep, tog_last;
	logic hs, br, ep_en, ep_dbl, ep_zlp, tog, over;
	logic [1:0] ep_kind, ep_trans;
	logic [10:0] ep_size;
	logic [15:0] ep_cnt;
	logic [14:0] total;
	logic [7:0] tog_cnt;
	int err_count = 0;
	int comparisons = 0;
	always #25 clk_i = ~clk_i;

	uec_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .adr_i(adr), .dat_i(wdat), .dat_o(dat_o),
		.we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o), .usb_bus_reset_i(br),
		.hs_mode_i(hs), .usb_ep_sel_i(ep_sel), .ep_enable_o(ep_en), .ep_kind_o(ep_kind),
		.ep_double_buffer_o(ep_dbl), .ep_suppress_zlp_o(ep_zlp), .ep_fifo_size_o(ep_size),
		.ep_trans_o(ep_trans), .ep_byte_count_o(ep_cnt), .toggle_reset_o(tog), .toggle_ep_o(tog_ep),
		.alloc_total_o(total), .alloc_over_o(over));
	uec_usb_host_model host (.clk_i(clk_i), .rst_i(rst_i), .sel_req_i(sel_req), .hs_req_i(hs_req),
		.bus_reset_req_i(br_req), .toggle_reset_i(tog), .toggle_ep_i(tog_ep), .usb_ep_sel_o(ep_sel),
		.hs_mode_o(hs), .usb_bus_reset_o(br), .toggle_count_o(tog_cnt), .toggle_last_o(tog_last));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic close_out;
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// classic cycle: held until ack is sampled, read data taken at that edge
	// a missing ack is left to the watchdog
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		sel <= 4'h0;
		@(posedge clk_i);
	endtask : wb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, 4'h3, q);
	endtask : wr

	task automatic wrl(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		wb(1'b1, a, d, s, q);
	endtask : wrl

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, 4'h3, q);
		chk(q, e);
	endtask : rd

	// endpoint select goes through the host flop, then the design flop
	task automatic usb(input logic [2:0] e, input logic h);
		sel_req <= e;
		hs_req <= h;
		repeat (4) @(posedge clk_i);
	endtask : usb

	task automatic cfg(input logic [2:0] e, input logic [31:0] size, input logic [31:0] ty);
		wr(uec_pkg::OFS_EP_INDEX, 32'(e));
		wr(uec_pkg::OFS_FIFO_SIZE, size);
		wr(uec_pkg::OFS_TYPE_CTRL, ty);
		usb(e, 1'b0);
	endtask : cfg

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (5000) @(posedge clk_i);
		err_count++;
		close_out();
	end

	initial begin
		logic [1:0] et;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(uec_pkg::OFS_TYPE_CTRL, 32'h0);
		rd(uec_pkg::OFS_FIFO_SIZE, 32'h0);
		wr(uec_pkg::OFS_EP_INDEX, 32'h2);
		for (int t = 0; t < 4; t++) begin
			wr(uec_pkg::OFS_FIFO_SIZE, 32'h40 | (t << 11));
			rd(uec_pkg::OFS_FIFO_SIZE, 32'h40 | (t << 11));
			rd(uec_pkg::OFS_BYTE_COUNT, 32'h40);
			for (int k = 1; k < 4; k++) begin
				wr(uec_pkg::OFS_TYPE_CTRL, 32'(k));
				for (int h = 0; h < 2; h++) begin
					usb(3'h2, 1'(h));
					et = (h == 1 && k != 2 && t != 3) ? 2'(t) : 2'h0;
					chk(32'(ep_kind), 32'(k));
					chk(32'(ep_trans), 32'(et));
					chk(32'(ep_size), 32'h40);
				end
			end
		end
		// reserved bits are written with their reset value
		wr(uec_pkg::OFS_TYPE_CTRL, 32'h0000001d);
		rd(uec_pkg::OFS_TYPE_CTRL, 32'h1d);
		usb(3'h2, 1'b0);
		chk({29'h0, ep_en, ep_dbl, ep_zlp}, 32'h7);
		wr(uec_pkg::OFS_TYPE_CTRL, 32'h15);
		wr(uec_pkg::OFS_TYPE_CTRL, 32'h1d);
		usb(3'h2, 1'b0);
		chk({21'h0, tog_last, tog_cnt}, {21'h0, 3'h2, 8'h02});
		rd(uec_pkg::OFS_ALLOC_STATUS, 32'h80);
		// total exactly at the limit, then one byte over
		for (int e = 3; e < 6; e++) begin
			cfg(3'(e), 32'h400, 32'h0e);
		end
		cfg(3'h2, 32'h400, 32'h1d);
		rd(uec_pkg::OFS_ALLOC_STATUS, 32'h2000);
		cfg(3'h6, 32'h001, 32'h0a);
		chk({16'h0, over, total}, 32'h0000a001);
		rd(uec_pkg::OFS_ALLOC_STATUS, 32'h12001);
		cfg(3'h6, 32'h001, 32'h02);
		chk({15'h0, over, total, ep_en}, 32'h00004000);
		// clock enable low freezes the endpoint view
		ce <= 1'b0;
		usb(3'h3, 1'b0);
		chk(32'(ep_size), 32'h001);
		ce <= 1'b1;
		usb(3'h3, 1'b0);
		chk(32'(ep_size), 32'h400);
		// usb bus reset clears configuration but keeps the index
		br_req <= 1'b1;
		repeat (2) @(posedge clk_i);
		br_req <= 1'b0;
		usb(3'h2, 1'b0);
		rd(uec_pkg::OFS_TYPE_CTRL, 32'h0);
		rd(uec_pkg::OFS_EP_INDEX, 32'h6);
		chk({16'h0, ep_cnt}, 32'h0);
		chk({16'h0, over, total}, 32'h0);
		// single byte lanes keep the other byte
		wrl(uec_pkg::OFS_FIFO_SIZE, 32'h00001fff, 4'h1);
		rd(uec_pkg::OFS_FIFO_SIZE, 32'h0ff);
		rd(uec_pkg::OFS_BYTE_COUNT, 32'h0ff);
		wrl(uec_pkg::OFS_FIFO_SIZE, 32'h00000a00, 4'h2);
		rd(uec_pkg::OFS_FIFO_SIZE, 32'haff);
		rd(uec_pkg::OFS_BYTE_COUNT, 32'h2ff);
		// a second reset clears index and configuration
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(uec_pkg::OFS_EP_INDEX, 32'h0);
		wr(uec_pkg::OFS_EP_INDEX, 32'h6);
		rd(uec_pkg::OFS_FIFO_SIZE, 32'h0);
		rd(uec_pkg::OFS_TYPE_CTRL, 32'h0);
		wr(12'h300, 32'h1234);
		rd(12'h300, 32'h0);
		close_out();
	end
endmodule : uec_regs_tb_top
`default_nettype wire
